// *** verilog/mdec_decoder.sv ***
// program, internal, special-function and external data space decoder
// Behaviour
// - ea high: fetch on-chip up to FFFH
// - ea high: 1000H and above go external
// - ea low: every fetch goes external
// - program addressed by 16-bit counter, 64 Kbytes
// - fetches at 03H..2BH flagged interrupt entries
// - sfr area direct only; ram direct and indirect
// - ram 00H..1FH is banked register area
// - bit n maps byte 20H+n/8, bit n%8
// - bit segment bytes also byte accessible
// - ram 30H..7FH is scratch pad
// - stack anywhere in 128-byte ram
// - external data by 16-bit address, or page byte plus pointer register
// - four banks of eight registers, one active
// - status word bits 3,4 select bank
// - reset selects bank 0
// - opcode field picks register of active bank
// - only registers zero and one point indirectly
// - reset loads stack pointer with 07H
// - increment before push, decrement after pop
module mdec_decoder
  import mdec_pkg::*;
#(
  parameter int RAM_AW = MDEC_RAM_AW
) (
  input  wire logic        clock,                  // core clock
  input  wire logic        rst_n,                  // async reset
  input  wire logic        external_access_select, // pin, async
  input  wire logic        fetch_req,              // fetch strobe
  input  wire logic [15:0] fetch_addr,             // program counter
  output logic             prog_valid_q,           // fetch decoded
  output logic             prog_onchip_q,          // on-chip rom
  output logic             prog_external_q,        // external memory
  output logic      [15:0] prog_addr_q,            // fetch address
  output logic             prog_vector_q,          // interrupt entry
  input  wire logic        req,                    // data request
  input  wire mdec_op_t    op,                     // data operation
  input  wire logic [7:0]  addr,                   // direct or bit addr
  input  wire logic [2:0]  reg_idx,                // opcode reg field
  input  wire logic        ptr_sel,                // pointer one if set
  input  wire logic [7:0]  wdata,                  // write byte
  input  wire logic        bit_val,                // bit write value
  input  wire logic [15:0] xaddr,                  // external address
  input  wire logic [7:0]  xpage,                  // high byte, pointer
  output logic             busy_q,                 // request in flight
  output logic             done_q,                 // request complete
  output logic      [7:0]  rdata_q,                // read result
  output logic             err_q,                  // request refused
  output logic             sfr_req_q,              // sfr access
  output logic             sfr_we_q,               // sfr write
  output logic      [7:0]  sfr_addr_q,             // sfr address
  output logic      [7:0]  sfr_wdata_q,            // sfr write data
  input  wire logic [7:0]  sfr_rdata,              // sfr data, next cyc
  output logic             xdata_req_q,            // external data
  output logic             xdata_we_q,             // external write
  output logic      [15:0] xdata_addr_q,           // external address
  output logic      [7:0]  xdata_wdata_q,          // external wdata
  output logic      [1:0]  bank_q,                 // active bank
  output logic      [7:0]  sp_q                    // stack pointer
);

  if (RAM_AW != MDEC_RAM_AW) begin : g_chk
    $error("mdec_decoder: internal ram must span 128 bytes");
  end

  // external access pin synchroniser
  logic ea_s1_q, ea_s2_q, ea_s3_q, ea_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ea_s1_q <= MDEC_EA_RESET;
      ea_s2_q <= MDEC_EA_RESET;
      ea_s3_q <= MDEC_EA_RESET;
      ea_q    <= MDEC_EA_RESET;
    end else begin
      ea_s1_q <= external_access_select;
      ea_s2_q <= ea_s1_q;
      ea_s3_q <= ea_s2_q;
      if (ea_s2_q == ea_s3_q) begin
        ea_q <= ea_s3_q;
      end
    end
  end

  // program fetch steering
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prog_valid_q    <= 1'b0;
      prog_onchip_q   <= 1'b0;
      prog_external_q <= 1'b0;
      prog_addr_q     <= '0;
      prog_vector_q   <= 1'b0;
    end else begin
      prog_valid_q <= fetch_req;
      prog_addr_q  <= fetch_addr;
      prog_onchip_q <= fetch_req && ea_q && (fetch_addr <= MDEC_ROM_LAST);
      prog_external_q <= fetch_req &&
                         (!ea_q || (fetch_addr > MDEC_ROM_LAST));
      prog_vector_q <= fetch_req && (fetch_addr >= MDEC_VEC_FIRST) &&
                       (fetch_addr <= MDEC_VEC_LAST);
    end
  end

  // data side
  mdec_state_t st_q, st_d;
  mdec_op_t    op_q;
  logic [7:0]  tgt_q, tgt_d;
  logic [2:0]  bitpos_q;
  logic [7:0]  wdata_q;
  logic        bitv_q;
  logic [7:0]  xpage_q;

  logic              ram_we;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0]        ram_wdata;
  logic [7:0]        ram_rdata;

  logic        fin, fin_err;
  logic [7:0]  fin_data;
  logic        sfr_go, sfr_wr, xd_go, xd_wr;
  logic [15:0] xd_addr;
  logic [7:0]  xd_wdata;
  logic [7:0]  sp_d;
  logic [1:0]  bank_d;
  logic [7:0]  reg_addr, ptr_addr, bit_byte, sp_inc, sp_dec;

  assign reg_addr = {3'h0, bank_q, reg_idx};
  assign ptr_addr = {3'h0, bank_q, 2'h0, ptr_sel};
  // byte 20H plus n over eight
  assign bit_byte = MDEC_BIT_BASE + {4'h0, addr[6:3]};
  assign sp_inc   = sp_q + 8'h01;
  assign sp_dec   = sp_q - 8'h01;

  mdec_ram #(
    .AW (RAM_AW),
    .DW (8)
  ) u_ram (
    .clock   (clock),
    .rst_n   (rst_n),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata_q (ram_rdata)
  );

  always_comb begin
    st_d      = st_q;
    tgt_d     = tgt_q;
    ram_we    = 1'b0;
    ram_addr  = '0;
    ram_wdata = wdata;
    fin       = 1'b0;
    fin_err   = 1'b0;
    fin_data  = 8'h00;
    sfr_go    = 1'b0;
    sfr_wr    = 1'b0;
    xd_go     = 1'b0;
    xd_wr     = 1'b0;
    xd_addr   = xaddr;
    xd_wdata  = wdata;
    sp_d      = sp_q;
    bank_d    = bank_q;
    unique case (st_q)
      MDEC_ST_IDLE: begin
        if (req) begin
          tgt_d = addr;
          case (op)
            // low half is ram, high is sfr
            MDEC_OP_DIR_RD, MDEC_OP_DIR_WR: begin
              ram_addr = addr[RAM_AW-1:0];
              if (addr <= MDEC_RAM_LAST) begin
                ram_we = (op == MDEC_OP_DIR_WR);
                fin    = ram_we;
                st_d   = ram_we ? MDEC_ST_IDLE : MDEC_ST_RD;
              end else if (addr == MDEC_ADDR_SP) begin
                fin      = 1'b1;
                fin_data = sp_q;
                if (op == MDEC_OP_DIR_WR) begin
                  sp_d = wdata;
                end
              end else begin
                sfr_go = 1'b1;
                sfr_wr = (op == MDEC_OP_DIR_WR);
                fin    = sfr_wr;
                st_d   = sfr_wr ? MDEC_ST_IDLE : MDEC_ST_SFR;
                // bank bits follow status word writes
                if (sfr_wr && addr == MDEC_ADDR_PSW) begin
                  bank_d = wdata[MDEC_PSW_BANK_LSB +: 2];
                end
              end
            end
            MDEC_OP_IND_RD, MDEC_OP_IND_WR,
            MDEC_OP_XIND_RD, MDEC_OP_XIND_WR: begin
              ram_addr = ptr_addr[RAM_AW-1:0];
              st_d     = MDEC_ST_PTR;
            end
            MDEC_OP_REG_RD, MDEC_OP_REG_WR: begin
              ram_addr = reg_addr[RAM_AW-1:0];
              ram_we   = (op == MDEC_OP_REG_WR);
              fin      = ram_we;
              st_d     = ram_we ? MDEC_ST_IDLE : MDEC_ST_RD;
            end
            MDEC_OP_BIT_RD, MDEC_OP_BIT_WR: begin
              ram_addr = bit_byte[RAM_AW-1:0];
              tgt_d    = bit_byte;
              if (addr > MDEC_RAM_LAST) begin
                fin     = 1'b1;
                fin_err = 1'b1;
              end else begin
                st_d = (op == MDEC_OP_BIT_WR) ? MDEC_ST_RMW : MDEC_ST_RD;
              end
            end
            MDEC_OP_PUSH: begin
              fin      = 1'b1;
              ram_addr = sp_inc[RAM_AW-1:0];
              if (sp_q >= MDEC_RAM_LAST) begin
                fin_err = 1'b1;
              end else begin
                ram_we = 1'b1;
                sp_d   = sp_inc;
              end
            end
            MDEC_OP_POP: begin
              ram_addr = sp_q[RAM_AW-1:0];
              if (sp_q > MDEC_RAM_LAST) begin
                fin     = 1'b1;
                fin_err = 1'b1;
              end else begin
                st_d = MDEC_ST_RD;
              end
            end
            MDEC_OP_XRD, MDEC_OP_XWR: begin
              xd_go = 1'b1;
              xd_wr = (op == MDEC_OP_XWR);
              fin   = 1'b1;
            end
            default: begin
              fin     = 1'b1;
              fin_err = 1'b1;
            end
          endcase
        end
      end
      MDEC_ST_PTR: begin
        tgt_d    = ram_rdata;
        ram_addr = ram_rdata[RAM_AW-1:0];
        st_d     = MDEC_ST_IDLE;
        if (op_q == MDEC_OP_XIND_RD || op_q == MDEC_OP_XIND_WR) begin
          xd_go    = 1'b1;
          xd_wr    = (op_q == MDEC_OP_XIND_WR);
          xd_addr  = {xpage_q, ram_rdata};
          xd_wdata = wdata_q;
          fin      = 1'b1;
        end else if (ram_rdata > MDEC_RAM_LAST) begin
          // indirect never reaches the sfr area
          fin     = 1'b1;
          fin_err = 1'b1;
        end else if (op_q == MDEC_OP_IND_WR) begin
          ram_we    = 1'b1;
          ram_wdata = wdata_q;
          fin       = 1'b1;
        end else begin
          st_d = MDEC_ST_RD;
        end
      end
      MDEC_ST_RD: begin
        fin      = 1'b1;
        st_d     = MDEC_ST_IDLE;
        fin_data = ram_rdata;
        if (op_q == MDEC_OP_BIT_RD) begin
          fin_data = {7'h00, ram_rdata[bitpos_q]};
        end
        if (op_q == MDEC_OP_POP) begin
          sp_d = sp_dec;
        end
      end
      MDEC_ST_RMW: begin
        ram_addr            = tgt_q[RAM_AW-1:0];
        ram_wdata           = ram_rdata;
        ram_wdata[bitpos_q] = bitv_q;
        ram_we              = 1'b1;
        fin                 = 1'b1;
        st_d                = MDEC_ST_IDLE;
      end
      MDEC_ST_SFR: begin
        fin      = 1'b1;
        st_d     = MDEC_ST_IDLE;
        fin_data = sfr_rdata;
        if (tgt_q == MDEC_ADDR_PSW) begin
          fin_data[MDEC_PSW_BANK_LSB +: 2] = bank_q;
        end
      end
      default: begin
        st_d = MDEC_ST_IDLE;
      end
    endcase
  end

  // sequencer and captured request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= MDEC_ST_IDLE;
      op_q     <= MDEC_OP_DIR_RD;
      tgt_q    <= '0;
      bitpos_q <= '0;
      wdata_q  <= '0;
      bitv_q   <= 1'b0;
      xpage_q  <= '0;
      busy_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      tgt_q  <= tgt_d;
      busy_q <= (st_d != MDEC_ST_IDLE);
      if (st_q == MDEC_ST_IDLE && req) begin
        op_q     <= op;
        bitpos_q <= addr[2:0];
        wdata_q  <= wdata;
        bitv_q   <= bit_val;
        xpage_q  <= xpage;
      end
    end
  end

  // bank 0 and stack at 07H after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= MDEC_BANK_RESET;
      sp_q   <= MDEC_SP_RESET;
    end else begin
      bank_q <= bank_d;
      sp_q   <= sp_d;
    end
  end

  // completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= fin;
      err_q  <= fin && fin_err;
      if (fin) begin
        rdata_q <= fin_data;
      end
    end
  end

  // sfr and external data strobes, one cycle each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_req_q     <= 1'b0;
      sfr_we_q      <= 1'b0;
      sfr_addr_q    <= '0;
      sfr_wdata_q   <= '0;
      xdata_req_q   <= 1'b0;
      xdata_we_q    <= 1'b0;
      xdata_addr_q  <= '0;
      xdata_wdata_q <= '0;
    end else begin
      sfr_req_q   <= sfr_go;
      sfr_we_q    <= sfr_wr;
      xdata_req_q <= xd_go;
      xdata_we_q  <= xd_wr;
      if (sfr_go) begin
        sfr_addr_q  <= addr;
        sfr_wdata_q <= wdata;
      end
      if (xd_go) begin
        xdata_addr_q  <= xd_addr;
        xdata_wdata_q <= xd_wdata;
      end
    end
  end

endmodule

// *** verilog/mdec_pkg.sv ***
// shared constants and types for the memory space decoder
package mdec_pkg;

  // program space
  localparam logic [15:0] MDEC_ROM_LAST     = 16'h0FFF;
  localparam logic [15:0] MDEC_VEC_FIRST    = 16'h0003;
  localparam logic [15:0] MDEC_VEC_LAST     = 16'h002B;

  // internal data space
  localparam int          MDEC_RAM_AW       = 7;
  localparam logic [7:0]  MDEC_REG_LAST     = 8'h1F;
  localparam logic [7:0]  MDEC_BIT_BASE     = 8'h20;
  localparam logic [7:0]  MDEC_BIT_LAST     = 8'h2F;
  localparam logic [7:0]  MDEC_SCRATCH_BASE = 8'h30;
  localparam logic [7:0]  MDEC_RAM_LAST     = 8'h7F;
  localparam logic [7:0]  MDEC_SFR_BASE     = 8'h80;

  // special-function registers owned here, bank field and reset values
  localparam logic [7:0]  MDEC_ADDR_PSW     = 8'hD0;
  localparam logic [7:0]  MDEC_ADDR_SP      = 8'h81;
  localparam int          MDEC_PSW_BANK_LSB = 3;
  localparam logic [7:0]  MDEC_SP_RESET     = 8'h07;
  localparam logic [1:0]  MDEC_BANK_RESET   = 2'h0;
  localparam logic        MDEC_EA_RESET     = 1'b0;

  typedef enum logic [3:0] {
    MDEC_OP_DIR_RD  = 4'h0,
    MDEC_OP_DIR_WR  = 4'h1,
    MDEC_OP_IND_RD  = 4'h2,
    MDEC_OP_IND_WR  = 4'h3,
    MDEC_OP_REG_RD  = 4'h4,
    MDEC_OP_REG_WR  = 4'h5,
    MDEC_OP_BIT_RD  = 4'h6,
    MDEC_OP_BIT_WR  = 4'h7,
    MDEC_OP_PUSH    = 4'h8,
    MDEC_OP_POP     = 4'h9,
    MDEC_OP_XRD     = 4'hA,
    MDEC_OP_XWR     = 4'hB,
    MDEC_OP_XIND_RD = 4'hC,
    MDEC_OP_XIND_WR = 4'hD
  } mdec_op_t;

  typedef enum logic [2:0] {
    MDEC_ST_IDLE = 3'h0,
    MDEC_ST_PTR  = 3'h1,
    MDEC_ST_RD   = 3'h2,
    MDEC_ST_RMW  = 3'h3,
    MDEC_ST_SFR  = 3'h4
  } mdec_state_t;

endpackage

// *** verilog/mdec_ram.sv ***
// internal data ram, synchronous write and registered read
module mdec_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clock,   // core clock
  input  wire logic          rst_n,   // async reset, active low
  input  wire logic          we,      // write strobe
  input  wire logic [AW-1:0] addr,    // byte address
  input  wire logic [DW-1:0] wdata,   // write data
  output logic      [DW-1:0] rdata_q  // read data, one cycle after addr
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read-before-write: a same-cycle write shows on the next access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[addr];
    end
  end

endmodule

// *** tb/mdec_chk_assertions.sv ***
// concurrent checks on the decoder top-level ports
module mdec_chk
  import mdec_pkg::*;
(
  input wire logic        clock,           // core clock
  input wire logic        rst_n,           // async reset
  input wire logic        fetch_req,       // fetch strobe
  input wire logic [15:0] fetch_addr,      // program counter
  input wire logic        prog_valid_q,    // fetch decoded
  input wire logic        prog_onchip_q,   // on-chip rom
  input wire logic        prog_external_q, // external memory
  input wire logic        prog_vector_q,   // interrupt entry
  input wire logic        req,             // data request
  input wire mdec_op_t    op,              // data operation
  input wire logic [7:0]  addr,            // direct or bit addr
  input wire logic [7:0]  wdata,           // write byte
  input wire logic [15:0] xaddr,           // external address
  input wire logic        busy_q,          // request in flight
  input wire logic        done_q,          // completion
  input wire logic        err_q,           // refused
  input wire logic        sfr_req_q,       // sfr access
  input wire logic [7:0]  sfr_addr_q,      // sfr address
  input wire logic        xdata_req_q,     // external data
  input wire logic [15:0] xdata_addr_q,    // external address
  input wire logic [1:0]  bank_q,          // active bank
  input wire logic [7:0]  sp_q             // stack pointer
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_rom_limit: assert property (
    prog_onchip_q |-> $past(fetch_addr) <= 16'h0FFF)
    else $error("on-chip fetch above rom limit");
  a_high_external: assert property (
    fetch_req && fetch_addr > 16'h0FFF |=> prog_external_q && !prog_onchip_q)
    else $error("high fetch not sent external");
  a_one_target: assert property (
    prog_valid_q |-> prog_onchip_q != prog_external_q)
    else $error("fetch target not unique");
  a_vector_flag: assert property (
    fetch_req |=> prog_vector_q == ($past(fetch_addr) >= 16'h0003
                                 && $past(fetch_addr) <= 16'h002B))
    else $error("vector flag wrong");
  a_reset_state: assert property (
    $rose(rst_n) |-> bank_q == 2'h0 && sp_q == 8'h07)
    else $error("bank or stack pointer wrong after reset");
  a_push_order: assert property (
    req && !busy_q && op == MDEC_OP_PUSH && sp_q < 8'h7F
    |=> done_q && sp_q == $past(sp_q) + 8'h01)
    else $error("push did not pre-increment");
  a_pop_order: assert property (
    req && !busy_q && op == MDEC_OP_POP && sp_q <= 8'h7F
    |-> ##2 done_q && sp_q == $past(sp_q, 2) - 8'h01)
    else $error("pop did not post-decrement");
  a_bank_select: assert property (
    req && !busy_q && op == MDEC_OP_DIR_WR && addr == 8'hD0
    |=> bank_q == $past(wdata[4:3]))
    else $error("bank not taken from status bits");
  a_sfr_direct: assert property (
    sfr_req_q |-> sfr_addr_q[7] && sfr_addr_q != 8'h81)
    else $error("sfr port reached below 80 or at pointer");
  a_bit_refuse: assert property (
    req && !busy_q && op == MDEC_OP_BIT_RD && addr[7] |=> done_q && err_q)
    else $error("bit number above 7F not refused");
  a_xdata_addr: assert property (
    req && !busy_q && op == MDEC_OP_XRD
    |=> xdata_req_q && done_q && xdata_addr_q == $past(xaddr))
    else $error("external read address wrong");
endmodule

bind mdec_decoder mdec_chk u_chk (
  .clock, .rst_n, .fetch_req, .fetch_addr, .prog_valid_q, .prog_onchip_q,
  .prog_external_q, .prog_vector_q, .req, .op, .addr, .wdata, .xaddr,
  .busy_q, .done_q, .err_q, .sfr_req_q, .sfr_addr_q, .xdata_req_q,
  .xdata_addr_q, .bank_q, .sp_q
);

// *** tb/mdec_sfr_model.sv ***
// far-side model: special-function storage behind the sfr port
module mdec_sfr_model (
  input  wire logic       clock,       // core clock
  input  wire logic       rst_n,       // async reset
  input  wire logic       sfr_req_q,   // access strobe
  input  wire logic       sfr_we_q,    // write strobe
  input  wire logic [7:0] sfr_addr_q,  // register address
  input  wire logic [7:0] sfr_wdata_q, // write data
  output logic      [7:0] sfr_rdata    // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [7:0] last_q;
  logic       rd_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      last_q <= 8'h00;
    end else begin
      rd_q <= sfr_req_q && !sfr_we_q;
      last_q <= sfr_rdata;
      if (sfr_req_q && sfr_we_q) begin
        mem[sfr_addr_q] <= sfr_wdata_q;
      end
    end
  end
  // valid during and after a read; otherwise toggles so stale data shows
  assign sfr_rdata = ((sfr_req_q && !sfr_we_q) || rd_q) ?
                     mem[sfr_addr_q] : ~last_q;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the memory space decoder
module tb
  import mdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst_n = 1'b0, external_access_select = 1'b0;
  logic        fetch_req = 1'b0, req = 1'b0, ptr_sel = 1'b0, bit_val = 1'b0;
  logic [15:0] fetch_addr = 16'h0000, xaddr = 16'h0000;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, xpage = 8'h00;
  logic [2:0]  reg_idx = 3'h0;
  mdec_op_t    op = MDEC_OP_DIR_RD;
  logic        prog_valid_q, prog_onchip_q, prog_external_q, prog_vector_q;
  logic        busy_q, done_q, err_q, sfr_req_q, sfr_we_q;
  logic        xdata_req_q, xdata_we_q, er;
  logic [15:0] prog_addr_q, xdata_addr_q;
  logic [7:0]  rdata_q, sfr_addr_q, sfr_wdata_q, sfr_rdata, xdata_wdata_q;
  logic [7:0]  sp_q, rd;
  logic [1:0]  bank_q;
  int          n_fail, n_tests, cyc;

  mdec_decoder u_dut (
    .clock, .rst_n, .external_access_select, .fetch_req, .fetch_addr,
    .prog_valid_q, .prog_onchip_q, .prog_external_q, .prog_addr_q,
    .prog_vector_q, .req, .op, .addr, .reg_idx, .ptr_sel, .wdata, .bit_val,
    .xaddr, .xpage, .busy_q, .done_q, .rdata_q, .err_q, .sfr_req_q,
    .sfr_we_q, .sfr_addr_q, .sfr_wdata_q, .sfr_rdata, .xdata_req_q,
    .xdata_we_q, .xdata_addr_q, .xdata_wdata_q, .bank_q, .sp_q
  );
  mdec_sfr_model u_sfr (
    .clock, .rst_n, .sfr_req_q, .sfr_we_q, .sfr_addr_q, .sfr_wdata_q,
    .sfr_rdata
  );

  initial begin
    forever #50 clock = ~clock;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask

  task automatic fetch(input logic [15:0] a, input logic [2:0] exp);
    fetch_req = 1'b1;
    fetch_addr = a;
    tick(1);
    chk({prog_valid_q, prog_onchip_q, prog_external_q, prog_vector_q},
        {1'b1, exp});
  endtask

  // one idle edge before each request, so req never flips twice in a step
  task automatic dreq(input mdec_op_t o, input logic [7:0] a,
                      input logic [7:0] d);
    int k;
    tick(1);
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    tick(1);
    req = 1'b0;
    k = 0;
    while (done_q !== 1'b1 && k < 5) begin
      tick(1);
      k++;
    end
    if (k == 5) begin
      n_fail++;
      $display("mismatch at %0t: request never completed", $time);
    end
    rd = rdata_q;
    er = err_q;
  endtask

  task automatic t_stack();
    dreq(MDEC_OP_PUSH, 8'h00, 8'h55);
    chk(sp_q, 8'h08);
    dreq(MDEC_OP_DIR_RD, 8'h08, 8'h00);
    chk(rd, 8'h55);
    dreq(MDEC_OP_DIR_WR, 8'h81, 8'h7E);
    dreq(MDEC_OP_PUSH, 8'h00, 8'h66);
    chk(sp_q, 8'h7F);
    dreq(MDEC_OP_PUSH, 8'h00, 8'h77);
    chk(er, 1'b1);
    dreq(MDEC_OP_POP, 8'h00, 8'h00);
    chk({rd, sp_q}, 16'h667E);
  endtask

  task automatic t_fetch();
    logic [15:0] a [7] = '{16'h0000, 16'h0003, 16'h002B, 16'h002C,
                           16'h0FFF, 16'h1000, 16'hFFFF};
    logic [2:0]  e [7] = '{3'h4, 3'h5, 3'h5, 3'h4, 3'h4, 3'h2, 3'h2};
    external_access_select = 1'b1;
    tick(6);
    for (int i = 0; i < 7; i++) begin
      fetch(a[i], e[i]);
    end
    external_access_select = 1'b0;
    tick(6);
    fetch(16'h0FFF, 3'h2);
    chk(prog_addr_q, 16'h0FFF);
    fetch_req = 1'b0;
  endtask

  task automatic t_ram();
    logic [7:0] v = 8'hA5;
    dreq(MDEC_OP_DIR_WR, 8'h30, 8'h3C);
    dreq(MDEC_OP_DIR_WR, 8'h7F, 8'hC3);
    dreq(MDEC_OP_DIR_WR, 8'h21, v);
    dreq(MDEC_OP_DIR_WR, 8'h2F, 8'h01);
    dreq(MDEC_OP_DIR_RD, 8'h30, 8'h00);
    chk(rd, 8'h3C);
    dreq(MDEC_OP_DIR_RD, 8'h7F, 8'h00);
    chk(rd, 8'hC3);
    for (int n = 8; n < 16; n++) begin
      dreq(MDEC_OP_BIT_RD, n[7:0], 8'h00);
      chk(rd, {7'h00, v[n - 8]});
    end
    bit_val = 1'b1;
    dreq(MDEC_OP_BIT_WR, 8'h7F, 8'h00);
    dreq(MDEC_OP_DIR_RD, 8'h2F, 8'h00);
    chk(rd, 8'h81);
    dreq(MDEC_OP_BIT_RD, 8'h80, 8'h00);
    chk(er, 1'b1);
  endtask

  task automatic t_bank();
    for (int b = 0; b < 4; b++) begin
      dreq(MDEC_OP_DIR_WR, 8'hD0, 8'(b << 3));
      tick(1);
      chk(bank_q, b[1:0]);
      reg_idx = 3'(7 - b);
      dreq(MDEC_OP_REG_WR, 8'h00, 8'(8'h50 + b));
    end
    for (int b = 0; b < 4; b++) begin
      dreq(MDEC_OP_DIR_RD, 8'(b * 8 + 7 - b), 8'h00);
      chk(rd, 8'(8'h50 + b));
    end
    dreq(MDEC_OP_DIR_WR, 8'hD0, 8'h00);
  endtask

  task automatic t_ind();
    dreq(MDEC_OP_DIR_WR, 8'h01, 8'h40);
    dreq(MDEC_OP_DIR_WR, 8'h40, 8'h77);
    ptr_sel = 1'b1;
    dreq(MDEC_OP_IND_RD, 8'h00, 8'h00);
    chk(rd, 8'h77);
    dreq(MDEC_OP_IND_WR, 8'h00, 8'h99);
    dreq(MDEC_OP_DIR_RD, 8'h40, 8'h00);
    chk(rd, 8'h99);
    xpage = 8'hAB;
    dreq(MDEC_OP_XIND_RD, 8'h00, 8'h00);
    chk(xdata_addr_q, 16'hAB40);
    dreq(MDEC_OP_DIR_WR, 8'h00, 8'h90);
    ptr_sel = 1'b0;
    dreq(MDEC_OP_IND_RD, 8'h00, 8'h00);
    chk(er, 1'b1);
    dreq(MDEC_OP_DIR_WR, 8'h90, 8'h3C);
    dreq(MDEC_OP_DIR_RD, 8'h90, 8'h00);
    chk(rd, 8'h3C);
  endtask

  task automatic t_ext();
    xaddr = 16'hFFFF;
    dreq(MDEC_OP_XWR, 8'h00, 8'h5A);
    chk({xdata_req_q, xdata_we_q, xdata_wdata_q}, 10'h35A);
    chk(xdata_addr_q, 16'hFFFF);
    xaddr = 16'h0000;
    dreq(MDEC_OP_XRD, 8'h00, 8'h00);
    chk({xdata_req_q, xdata_we_q}, 2'h2);
    chk(xdata_addr_q, 16'h0000);
    for (int o = 14; o < 16; o++) begin
      dreq(mdec_op_t'(o[3:0]), 8'h00, 8'h00);
      chk(er, 1'b1);  // refused codes
    end
  endtask

  initial begin
    repeat (16) @(posedge clock);
    #10;
    rst_n = 1'b1;
    chk({bank_q, sp_q}, 10'h007);
    t_stack();
    t_fetch();
    t_ram();
    t_bank();
    t_ind();
    t_ext();
    results();
  end
endmodule
